// >>> core/lcc_regs.sv
// Functional notes
// - Boost register bits 5:0: enable, two gain-stage bits, three level bits.
// - Boost code resets to 20 hex, bypass with no boost.
// - Defined boost codes are 2A,30,32,39,35,37,3B,3D hex.
// - Swing fields reset to 03 hex; code 3F hex is refused.
// - Post-cursor bit 7 selects type, bits 6:0 hold the level.
// - Post-cursor codes 01,E8,88,90,A0 hex are defined; reset is 03 hex.
// - Threshold bits 3:2 de-assert level, bits 1:0 assert level.
// - Threshold fields each pick one of four levels, sixteen pairs in all; reset code is 00.
// - Idle/rate bit 5 set gives automatic idle detection, else bit 4.
// - Manual idle: bit 4 clear keeps output on, set mutes it.
// - Idle/rate bit 1 set gives automatic rate detection, else bit 0.
// - Manual rate: bit 0 clear low range, set high range.
`timescale 1ns/1ps
`include "lcc_cfg.svh"

module lcc_regs #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    // Register port
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    output logic                       reg_rvalid,
    output logic                       reg_err,
    // Input zero boost filter
    output logic                       boost_filter_en,
    output logic      [1:0]            gain_stage,
    output logic      [2:0]            boost_level,
    output logic                       boost_code_known,
    // Output port A zero driver
    output logic      [6:0]            out_a_swing,
    output logic                       post_cursor_enhanced,
    output logic      [6:0]            post_cursor_level,
    output logic                       post_cursor_known,
    // Input zero idle detector thresholds
    output logic      [1:0]            idle_deassert_code,
    output logic      [1:0]            idle_assert_code,
    // Output port B zero driver
    output logic      [6:0]            out_b_swing,
    output lcc_pkg::lcc_idle_mode_e    out_b_idle_mode,
    output lcc_pkg::lcc_rate_mode_e    out_b_rate_mode
);

    // Offsets are eight bits wide, so a narrower address cannot reach them
    if (ADDR_W < 8) begin : g_addr_w_chk
        $error("lcc_regs: ADDR_W must be at least 8");
    end

    // Masked write, or hold
    function automatic logic [7:0] lcc_upd(input logic [7:0] cur,
                                           input logic       wr,
                                           input logic [7:0] data,
                                           input logic [7:0] mask);
        lcc_upd = wr ? (data & mask) : cur;
    endfunction

    // Boost code is bypass or one of the listed levels
    function automatic logic lcc_boost_ok(input logic [5:0] code);
        logic [47:0] tbl;
        tbl = `LCC_BOOST_CODES;
        lcc_boost_ok = (code == `LCC_BOOST_BYPASS);
        for (int i = 0; i < 8; i++) begin
            if (tbl[i*6 +: 6] == code)
                lcc_boost_ok = 1'b1;
        end
    endfunction

    // Post-cursor code is one of the listed levels
    function automatic logic lcc_post_ok(input logic [7:0] code);
        logic [39:0] tbl;
        tbl = `LCC_POST_CODES;
        lcc_post_ok = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (tbl[i*8 +: 8] == code)
                lcc_post_ok = 1'b1;
        end
    endfunction

    logic [7:0]               boost_reg;
    logic [7:0]               swing_a_reg;
    logic [7:0]               post_a_reg;
    logic [7:0]               thresh_reg;
    logic [7:0]               idle_rate_reg;
    logic [7:0]               swing_b_reg;
    logic [7:0]               rdata_reg;
    logic                     rvalid_reg;
    logic                     err_reg;
    logic                     boost_ok_reg;
    logic                     post_ok_reg;
    lcc_pkg::lcc_idle_mode_e  idle_mode_reg;
    lcc_pkg::lcc_rate_mode_e  rate_mode_reg;
    lcc_pkg::lcc_idle_mode_e  idle_mode_next;
    lcc_pkg::lcc_rate_mode_e  rate_mode_next;

    // Address decode
    wire hit_boost   = (reg_addr == ADDR_W'(`LCC_OFS_BOOST));
    wire hit_swing_a = (reg_addr == ADDR_W'(`LCC_OFS_SWING_A));
    wire hit_post_a  = (reg_addr == ADDR_W'(`LCC_OFS_POST_A));
    wire hit_thresh  = (reg_addr == ADDR_W'(`LCC_OFS_THRESH));
    wire hit_idle    = (reg_addr == ADDR_W'(`LCC_OFS_IDLE_RATE));
    wire hit_swing_b = (reg_addr == ADDR_W'(`LCC_OFS_SWING_B));
    wire hit_any     = hit_boost | hit_swing_a | hit_post_a | hit_thresh
                     | hit_idle | hit_swing_b;

    // The reserved swing code would overdrive the output, so it is refused
    wire swing_bad   = (reg_wdata[6:0] == `LCC_SWING_RSVD);
    wire wr_swing_a  = reg_wr & hit_swing_a & ~swing_bad;
    wire wr_swing_b  = reg_wr & hit_swing_b & ~swing_bad;
    wire refused     = reg_wr & (hit_swing_a | hit_swing_b) & swing_bad;
    wire unmapped    = (reg_wr | reg_rd) & ~hit_any;

    // Next register values; reserved bits never stored
    wire [7:0] boost_next   = lcc_upd(boost_reg, reg_wr & hit_boost,
                                      reg_wdata, `LCC_MSK_BOOST);
    wire [7:0] swing_a_next = lcc_upd(swing_a_reg, wr_swing_a,
                                      reg_wdata, `LCC_MSK_SWING);
    wire [7:0] post_a_next  = lcc_upd(post_a_reg, reg_wr & hit_post_a,
                                      reg_wdata, `LCC_MSK_POST);
    wire [7:0] thresh_next  = lcc_upd(thresh_reg, reg_wr & hit_thresh,
                                      reg_wdata, `LCC_MSK_THRESH);
    wire [7:0] idle_next    = lcc_upd(idle_rate_reg, reg_wr & hit_idle,
                                      reg_wdata, `LCC_MSK_IDLE_RATE);
    wire [7:0] swing_b_next = lcc_upd(swing_b_reg, wr_swing_b,
                                      reg_wdata, `LCC_MSK_SWING);

    // Read-back mux; a read in the same cycle as a write returns the old value
    wire [7:0] rd_mux = ({8{hit_boost}}   & boost_reg)
                      | ({8{hit_swing_a}} & swing_a_reg)
                      | ({8{hit_post_a}}  & post_a_reg)
                      | ({8{hit_thresh}}  & thresh_reg)
                      | ({8{hit_idle}}    & idle_rate_reg)
                      | ({8{hit_swing_b}} & swing_b_reg);
    wire [7:0] rdata_next = reg_rd ? rd_mux : rdata_reg;

    // Idle and rate decision from the current register contents
    wire idle_auto = idle_rate_reg[`LCC_IDLE_AUTO_BIT];
    wire idle_sel  = idle_rate_reg[`LCC_IDLE_SEL_BIT];
    wire rate_auto = idle_rate_reg[`LCC_RATE_AUTO_BIT];
    wire rate_sel  = idle_rate_reg[`LCC_RATE_SEL_BIT];
    assign idle_mode_next = idle_auto ? lcc_pkg::LCC_IDLE_AUTO
                          : idle_sel  ? lcc_pkg::LCC_IDLE_MUTED
                          :             lcc_pkg::LCC_IDLE_ON;
    assign rate_mode_next = rate_auto ? lcc_pkg::LCC_RATE_AUTO
                          : rate_sel  ? lcc_pkg::LCC_RATE_HIGH
                          :             lcc_pkg::LCC_RATE_LOW;

    // Configuration registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            boost_reg     <= `LCC_RST_BOOST;
            swing_a_reg   <= `LCC_RST_SWING;
            post_a_reg    <= `LCC_RST_POST;
            thresh_reg    <= `LCC_RST_THRESH;
            idle_rate_reg <= `LCC_RST_IDLE_RATE;
            swing_b_reg   <= `LCC_RST_SWING;
        end else begin
            boost_reg     <= boost_next;
            swing_a_reg   <= swing_a_next;
            post_a_reg    <= post_a_next;
            thresh_reg    <= thresh_next;
            idle_rate_reg <= idle_next;
            swing_b_reg   <= swing_b_next;
        end
    end

    // Read answer and error pulse
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
            err_reg    <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= reg_rd;
            err_reg    <= unmapped | refused;
        end
    end

    // Decoded modes lag the register by one cycle so every output is a flop
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            idle_mode_reg <= lcc_pkg::LCC_IDLE_ON;
            rate_mode_reg <= lcc_pkg::LCC_RATE_LOW;
            boost_ok_reg  <= 1'b1;
            post_ok_reg   <= 1'b0;
        end else begin
            idle_mode_reg <= idle_mode_next;
            rate_mode_reg <= rate_mode_next;
            boost_ok_reg  <= lcc_boost_ok(boost_reg[5:0]);
            post_ok_reg   <= lcc_post_ok(post_a_reg);
        end
    end

    // Outputs are plain slices of flops
    assign reg_rdata            = rdata_reg;
    assign reg_rvalid           = rvalid_reg;
    assign reg_err              = err_reg;
    assign boost_filter_en      = boost_reg[`LCC_BOOST_EN_BIT];
    assign gain_stage           = boost_reg[4:3];
    assign boost_level          = boost_reg[2:0];
    assign boost_code_known     = boost_ok_reg;
    assign out_a_swing          = swing_a_reg[6:0];
    assign post_cursor_enhanced = post_a_reg[`LCC_POST_TYPE_BIT];
    assign post_cursor_level    = post_a_reg[6:0];
    assign post_cursor_known    = post_ok_reg;
    assign idle_deassert_code   = thresh_reg[3:2];
    assign idle_assert_code     = thresh_reg[1:0];
    assign out_b_swing          = swing_b_reg[6:0];
    assign out_b_idle_mode      = idle_mode_reg;
    assign out_b_rate_mode      = rate_mode_reg;

    // First cycle after reset release, for reset-value checks
    logic first_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn)
            first_reg <= 1'b1;
        else
            first_reg <= 1'b0;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    boost_write_a: assert property (
        reg_wr && hit_boost |=> boost_reg == ($past(reg_wdata) & 8'h3F))
        else $error("boost register did not take masked write");
    boost_reset_a: assert property (
        first_reg |-> boost_reg == 8'h20 && boost_filter_en)
        else $error("boost register not bypass after reset");
    boost_known_a: assert property (
        reg_wr && hit_boost && reg_wdata == 8'h3D ##1 !reg_wr
        |=> boost_code_known)
        else $error("defined boost code not flagged known");
    swing_refuse_a: assert property (
        reg_wr && hit_swing_a && reg_wdata[6:0] == 7'h3F
        |=> $stable(swing_a_reg) && reg_err)
        else $error("reserved swing code was accepted");
    post_type_a: assert property (
        reg_wr && hit_post_a
        |=> post_cursor_enhanced == $past(reg_wdata[7]))
        else $error("post-cursor type bit wrong after write");
    post_known_a: assert property (
        reg_wr && hit_post_a && reg_wdata == 8'hE8 ##1 !reg_wr
        |=> post_cursor_known)
        else $error("defined post-cursor code not flagged known");
    thresh_split_a: assert property (
        reg_wr && hit_thresh |=> idle_deassert_code == $past(reg_wdata[3:2])
        && idle_assert_code == $past(reg_wdata[1:0]))
        else $error("threshold fields split wrongly");
    reset_vals_a: assert property (
        first_reg |-> thresh_reg == 8'h00 && swing_b_reg == 8'h03
        && post_a_reg == 8'h03)
        else $error("threshold, swing or post-cursor reset wrong");
    idle_auto_a: assert property (
        idle_rate_reg[5] |=> out_b_idle_mode == lcc_pkg::LCC_IDLE_AUTO)
        else $error("idle not automatic with bit 5 set");
    idle_manual_a: assert property (
        !idle_rate_reg[5] |=> out_b_idle_mode == ($past(idle_rate_reg[4])
        ? lcc_pkg::LCC_IDLE_MUTED : lcc_pkg::LCC_IDLE_ON))
        else $error("manual idle select not followed");
    rate_auto_a: assert property (
        idle_rate_reg[1] |=> out_b_rate_mode == lcc_pkg::LCC_RATE_AUTO)
        else $error("rate not automatic with bit 1 set");
    rate_manual_a: assert property (
        !idle_rate_reg[1] |=> out_b_rate_mode == ($past(idle_rate_reg[0])
        ? lcc_pkg::LCC_RATE_HIGH : lcc_pkg::LCC_RATE_LOW))
        else $error("manual rate select not followed");
    rsvd_zero_a: assert property (
        boost_reg[7:6] == 2'b00 && thresh_reg[7:4] == 4'h0
        && idle_rate_reg[7:6] == 2'b00 && idle_rate_reg[3:2] == 2'b00
        && swing_a_reg[7] == 1'b0 && swing_b_reg[7] == 1'b0)
        else $error("reserved bit holds a one");
    read_back_a: assert property (
        reg_rd && hit_idle |=> reg_rvalid && reg_rdata == $past(idle_rate_reg))
        else $error("read did not return register contents");

    mute_c: cover property (
        reg_wr && hit_idle && reg_wdata == 8'h10
        ##2 out_b_idle_mode == lcc_pkg::LCC_IDLE_MUTED);
    boost_max_c: cover property (
        reg_wr && hit_boost && reg_wdata == 8'h3D ##1 reg_rd && hit_boost);
    refuse_c: cover property (
        reg_wr && hit_swing_b && reg_wdata == 8'h3F ##1 reg_err);

endmodule // lcc_regs

// >>> core/lcc_cfg.svh
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH
// Register offsets
`define LCC_OFS_BOOST       8'h2C
`define LCC_OFS_SWING_A     8'h2D
`define LCC_OFS_POST_A      8'h2E
`define LCC_OFS_THRESH      8'h2F
`define LCC_OFS_IDLE_RATE   8'h32
`define LCC_OFS_SWING_B     8'h34
// Reset values
`define LCC_RST_BOOST       8'h20
`define LCC_RST_SWING       8'h03
`define LCC_RST_POST        8'h03
`define LCC_RST_THRESH      8'h00
`define LCC_RST_IDLE_RATE   8'h00
// Writable bits; reserved bits are dropped on write and read as zero
`define LCC_MSK_BOOST       8'h3F
`define LCC_MSK_SWING       8'h7F
`define LCC_MSK_POST        8'hFF
`define LCC_MSK_THRESH      8'h0F
`define LCC_MSK_IDLE_RATE   8'h33
// Field positions
`define LCC_BOOST_EN_BIT    5
`define LCC_POST_TYPE_BIT   7
`define LCC_IDLE_AUTO_BIT   5
`define LCC_IDLE_SEL_BIT    4
`define LCC_RATE_AUTO_BIT   1
`define LCC_RATE_SEL_BIT    0
// Swing code that must never reach the driver
`define LCC_SWING_RSVD      7'h3F
// Defined boost codes, bypass first, then 5 dB up to 28.4 dB at 3 GHz
`define LCC_BOOST_BYPASS    6'h20
`define LCC_BOOST_CODES     {6'h2A, 6'h30, 6'h32, 6'h39, 6'h35, 6'h37, \
                             6'h3B, 6'h3D}
// Defined post-cursor codes: 0, -3.5, -6, -9, -12 dB
`define LCC_POST_CODES      {8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0}
`endif

// >>> core/lcc_pkg.sv
package lcc_pkg;
    // How the output B idle state is decided
    typedef enum logic [2:0] {
        LCC_IDLE_AUTO   = 3'b001,
        LCC_IDLE_ON     = 3'b010,
        LCC_IDLE_MUTED  = 3'b100
    } lcc_idle_mode_e;
    // How the output B data rate is decided
    typedef enum logic [2:0] {
        LCC_RATE_AUTO   = 3'b001,
        LCC_RATE_LOW    = 3'b010,
        LCC_RATE_HIGH   = 3'b100
    } lcc_rate_mode_e;
endpackage

// >>> verification/lcc_regs_tb.sv
`timescale 1ns/1ps

module testbench;
    // Clock, reset and register port
    logic                    core_clk;
    logic                    rstn;
    logic [7:0]              reg_addr;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [7:0]              reg_wdata;
    logic [7:0]              reg_rdata;
    logic                    reg_rvalid;
    logic                    reg_err;
    // Field outputs
    logic                    boost_filter_en;
    logic [1:0]              gain_stage;
    logic [2:0]              boost_level;
    logic                    boost_code_known;
    logic [6:0]              out_a_swing;
    logic                    post_cursor_enhanced;
    logic [6:0]              post_cursor_level;
    logic                    post_cursor_known;
    logic [1:0]              idle_deassert_code;
    logic [1:0]              idle_assert_code;
    logic [6:0]              out_b_swing;
    lcc_pkg::lcc_idle_mode_e out_b_idle_mode;
    lcc_pkg::lcc_rate_mode_e out_b_rate_mode;
    int                      n_errors;
    int                      samples_checked;
    // Register map with reset values, and code tables
    logic [7:0] ofs_tab [6] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h32, 8'h34};
    logic [7:0] rst_tab [6] = '{8'h20, 8'h03, 8'h03, 8'h00, 8'h00, 8'h03};
    logic [5:0] boost_tab [9] = '{6'h20, 6'h2A, 6'h30, 6'h32, 6'h39, 6'h35,
                                  6'h37, 6'h3B, 6'h3D};
    logic [7:0] post_tab [5] = '{8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0};
    logic [7:0] swing_tab [3] = '{8'h07, 8'h0F, 8'h1F};
    // Idle/rate writes; expected {idle, rate}, one-hot AUTO=1 ON=2 MUTED=4
    logic [7:0] ir_val [7] = '{8'h00, 8'h10, 8'h30, 8'h21, 8'h11, 8'h03,
                               8'h02};
    logic [5:0] ir_exp [7] = '{6'h12, 6'h22, 6'h0A, 6'h0C, 6'h24, 6'h11,
                               6'h11};

    lcc_regs i_dut (
        .core_clk             (core_clk),
        .rstn                 (rstn),
        .reg_addr             (reg_addr),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_wdata            (reg_wdata),
        .reg_rdata            (reg_rdata),
        .reg_rvalid           (reg_rvalid),
        .reg_err              (reg_err),
        .boost_filter_en      (boost_filter_en),
        .gain_stage           (gain_stage),
        .boost_level          (boost_level),
        .boost_code_known     (boost_code_known),
        .out_a_swing          (out_a_swing),
        .post_cursor_enhanced (post_cursor_enhanced),
        .post_cursor_level    (post_cursor_level),
        .post_cursor_known    (post_cursor_known),
        .idle_deassert_code   (idle_deassert_code),
        .idle_assert_code     (idle_assert_code),
        .out_b_swing          (out_b_swing),
        .out_b_idle_mode      (out_b_idle_mode),
        .out_b_rate_mode      (out_b_rate_mode)
    );

    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One write; the error pulse is looked at in the answer cycle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
                          input logic e_err);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        #1;
        check({7'h00, reg_err}, {7'h00, e_err});
    endtask

    // One read; rvalid and data stand for the single answer cycle
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp,
                          input logic e_err);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        check({6'h00, reg_rvalid, reg_err}, {6'h00, 1'b1, e_err});
        check(reg_rdata, exp);
    endtask

    // Lagged outputs settle one cycle after the register
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
    endtask

    task automatic rst_chk();
        for (int i = 0; i < 6; i++) begin
            rd_reg(ofs_tab[i], rst_tab[i], 1'b0);
        end
        check({boost_filter_en, gain_stage, boost_level}, 8'h20);
        check({1'b0, boost_code_known, post_cursor_known}, 8'h02);
        check({2'h0, out_b_idle_mode, out_b_rate_mode}, 8'h12);
    endtask

    // Hang guard: a stuck run counts as a mismatch
    initial begin
        #2000000;
        n_errors++;
        end_sim();
    end

    initial begin
        n_errors = 0;
        samples_checked = 0;
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        do_reset();
        rst_chk();
        // Every listed boost code, then an unlisted one with reserved bits
        for (int i = 0; i < 9; i++) begin
            wr_reg(8'h2C, {2'b00, boost_tab[i]}, 1'b0);
            check({2'b00, boost_filter_en, gain_stage, boost_level},
                  {2'b00, boost_tab[i]});
            settle();
            check({7'h00, boost_code_known}, 8'h01);
        end
        wr_reg(8'h2C, 8'hFF, 1'b0);
        rd_reg(8'h2C, 8'h3F, 1'b0);
        check({7'h00, boost_code_known}, 8'h00);
        // Swing codes on both outputs, reserved bit 7 set on output A and dropped
        for (int i = 0; i < 3; i++) begin
            wr_reg(8'h2D, swing_tab[i] | 8'h80, 1'b0);
            wr_reg(8'h34, swing_tab[i], 1'b0);
            check({1'b0, out_a_swing}, swing_tab[i]);
            check({1'b0, out_b_swing}, swing_tab[i]);
        end
        // Reserved swing code is refused and leaves the setting alone
        wr_reg(8'h2D, 8'h3F, 1'b1);
        wr_reg(8'h34, 8'h3F, 1'b1);
        rd_reg(8'h2D, 8'h1F, 1'b0);
        rd_reg(8'h34, 8'h1F, 1'b0);
        // Post-cursor codes, both type settings among them
        for (int i = 0; i < 5; i++) begin
            wr_reg(8'h2E, post_tab[i], 1'b0);
            check({post_cursor_enhanced, post_cursor_level},
                  post_tab[i]);
            settle();
            check({7'h00, post_cursor_known}, 8'h01);
        end
        // Every threshold pair
        for (int i = 0; i < 16; i++) begin
            wr_reg(8'h2F, 8'(i), 1'b0);
            check({4'h0, idle_deassert_code, idle_assert_code}, 8'(i));
        end
        wr_reg(8'h2F, 8'hF5, 1'b0);
        rd_reg(8'h2F, 8'h05, 1'b0);
        // Idle and rate selection, automatic over manual
        for (int i = 0; i < 7; i++) begin
            wr_reg(8'h32, ir_val[i], 1'b0);
            settle();
            check({2'h0, out_b_idle_mode, out_b_rate_mode},
                  {2'h0, ir_exp[i]});
        end
        wr_reg(8'h32, 8'hFF, 1'b0);
        rd_reg(8'h32, 8'h33, 1'b0);
        // Unmapped place: error pulse, zero data, no effect
        wr_reg(8'h30, 8'hAA, 1'b1);
        rd_reg(8'h30, 8'h00, 1'b1);
        // Write and read in one cycle: the read sees the old value
        @(posedge core_clk);
        reg_addr  <= 8'h2F;
        reg_wdata <= 8'h0A;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        #1;
        check(reg_rdata, 8'h05);
        rd_reg(8'h2F, 8'h0A, 1'b0);
        // Second reset in mid-run brings every default back
        do_reset();
        rst_chk();
        end_sim();
    end
endmodule // testbench
